/* common/oscmc_defines.vh */
// oscmc_defines.vh: register map, field layout, mode codes and timing counts
// for the oscillator mode and internal clock block.
// assumes a 25 MHz aclk and an AXI4-Lite register bus with 32-bit data.
`ifndef OSCMC_DEFINES_VH
`define OSCMC_DEFINES_VH

// register byte offsets
`define OSCMC_TRIM_ADDR        8'h90
`define OSCMC_CTRL_ADDR        8'hA0
`define OSCMC_STAT_ADDR        8'hA4
`define OSCMC_ADDR_W           8

// trim register layout
`define OSCMC_TRIM_W           6
`define OSCMC_TRIM_RESET       6'h00
`define OSCMC_TRIM_MAX         6'h1F
`define OSCMC_TRIM_MIN         6'h20

// control register layout: freq select in bits 6:4
`define OSCMC_FSEL_LSB         4
`define OSCMC_FSEL_MSB         6
`define OSCMC_FSEL_RESET       3'h0
`define OSCMC_FSEL_SLOW        3'h0
`define OSCMC_FSEL_FAST        3'h7

// default mode codes (remappable through parameters)
`define OSCMC_CODE_LP          3'h0
`define OSCMC_CODE_XT          3'h1
`define OSCMC_CODE_HS          3'h2
`define OSCMC_CODE_RC          3'h3
`define OSCMC_CODE_RESISTOR_CAPACITOR_IO_MODE        3'h4
`define OSCMC_CODE_INT1        3'h5
`define OSCMC_CODE_INT2        3'h6
`define OSCMC_CODE_EC          3'h7

// clock source selection for the system clock mux
`define OSCMC_SRC_CRYSTAL      2'h0
`define OSCMC_SRC_RC           2'h1
`define OSCMC_SRC_INTERNAL     2'h2
`define OSCMC_SRC_EXTERNAL     2'h3

// timing: clock rate and settle times
`define OSCMC_ACLK_HZ          25000000
`define OSCMC_FAST_SETTLE_US   1000
`define OSCMC_FAST_SETTLE_CYC  ((`OSCMC_FAST_SETTLE_US * (`OSCMC_ACLK_HZ / 1000000)))
`define OSCMC_SLOW_SETTLE_EDGES 8
`define OSCMC_OST_CYC          1024

// nominal frequencies in Hz, and trim span in tenths of a percent
`define OSCMC_FAST_HZ          8000000
`define OSCMC_SLOW_HZ          31250
`define OSCMC_TRIM_SPAN_PCT_X10 125

// axi responses
`define OSCMC_RESP_OKAY        2'h0
`define OSCMC_RESP_SLVERR      2'h2

`endif

/* rtl/oscmc_divider.v */
// oscmc_divider.v: free-running power-of-two divider stage with an enable.
// assumes a single clock domain; the tick input marks one source edge.
`include "oscmc_defines.vh"

module oscmc_divider (
  input  wire aclk,
  input  wire aresetn,
  input  wire tick_in,
  output reg  tick_out,
  output reg  level
);

  // each stage halves the rate of the incoming tick train
  always @(posedge aclk) begin
    if (!aresetn) begin
      level    <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in & level;
      if (tick_in) begin
        level <= ~level;
      end
    end
  end

endmodule

/* rtl/oscmc_top.v */
// oscmc_top.v: oscillator mode decode, internal clock block and trim register.
// assumes the mode field is stable from reset, and that oscillator ticks
// arrive as one-cycle pulses synchronous to aclk.
//
// Functional notes
// - three-bit field picks one of eight modes
// - crystal modes use both oscillator pins
// - rc clkout mode drives osc/4 on output
// - rc io mode frees output pin as bit6
// - external clock from input, output becomes bit6
// - external clock mode skips start-up delay
// - internal clkout: osc/4 out, input is bit7
// - internal full io: both pins are port
// - fast internal clock is 8 MHz
// - postscaler gives six rates 125k-4M
// - slow internal clock 31.25 kHz, 32us
// - slow clock runs when selected or needed
// - freq select picks direct or postscaled
// - trim is signed, zero is centre
// - trim bits 7:6 read zero
// - constant trim step, both clocks, 12.5%
// - slow clock settles within 8 cycles
// - fast clock settles within 1 ms
// - no completion flag for trim change
// - slow-timed functions follow retuned rate
// - freq select codes 000..111 map rates
`include "oscmc_defines.vh"

module oscmc_top #(
  parameter [2:0]  CODE_LP       = `OSCMC_CODE_LP,
  parameter [2:0]  CODE_XT       = `OSCMC_CODE_XT,
  parameter [2:0]  CODE_HS       = `OSCMC_CODE_HS,
  parameter [2:0]  CODE_RC       = `OSCMC_CODE_RC,
  parameter [2:0]  CODE_RESISTOR_CAPACITOR_IO_MODE     = `OSCMC_CODE_RESISTOR_CAPACITOR_IO_MODE,
  parameter [2:0]  CODE_INT1     = `OSCMC_CODE_INT1,
  parameter [2:0]  CODE_INT2     = `OSCMC_CODE_INT2,
  parameter [2:0]  CODE_EC       = `OSCMC_CODE_EC,
  parameter [31:0] FAST_SETTLE   = `OSCMC_FAST_SETTLE_CYC,
  parameter [31:0] OST_CYCLES    = `OSCMC_OST_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [2:0]  osc_mode_select,
  input  wire        fast_tick,
  input  wire        slow_tick,
  input  wire        rc_tick,
  input  wire        osc_input_pin,
  input  wire        pwrt_enable,
  input  wire        wdt_enable,
  input  wire        two_speed_enable,
  input  wire        fscm_enable,
  input  wire        port_a_bit6_out,
  input  wire        port_a_bit6_oe_n,
  input  wire        port_a_bit7_out,
  input  wire        port_a_bit7_oe_n,
  output reg         osc_output_pin_out,
  output reg         osc_output_pin_oe_n,
  output reg         osc_input_pin_out,
  output reg         osc_input_pin_oe_n,
  output reg         port_a_bit6_io,
  output reg         port_a_bit7_io,
  output reg         sys_clk_tick,
  output reg  [1:0]  sys_clk_source,
  output reg         startup_done,
  output reg         slow_clock_run,
  output reg         slow_func_tick,
  output reg  [5:0]  trim_value_out,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  reg  [5:0]  trim_value;
  reg  [2:0]  internal_freq_select;
  reg  [2:0]  mode_reg;
  reg         mode_loaded;
  reg  [31:0] ost_count;
  reg  [31:0] fast_settle_count;
  reg  [3:0]  slow_settle_count;
  reg  [1:0]  quarter_count;
  reg  [7:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  wire [5:0]  post_tick;
  wire [5:0]  post_level;
  wire [5:0]  post_in;
  wire        crystal_mode;
  wire        rc_mode;
  wire        int_mode;
  wire        ext_mode;
  wire        int_src_tick;
  reg         next_int_tick;
  reg         next_src_tick;

  // the mode is latched once after reset release; a strap must not feed reset
  // mode capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_loaded <= 1'b0;
      mode_reg    <= 3'h0;
    end else if (!mode_loaded) begin
      mode_loaded <= 1'b1;
      mode_reg    <= osc_mode_select;
    end
  end

  assign crystal_mode = (mode_reg == CODE_LP) | (mode_reg == CODE_XT) | (mode_reg == CODE_HS);
  assign rc_mode      = (mode_reg == CODE_RC) | (mode_reg == CODE_RESISTOR_CAPACITOR_IO_MODE);
  assign int_mode     = (mode_reg == CODE_INT1) | (mode_reg == CODE_INT2);
  assign ext_mode     = (mode_reg == CODE_EC);

  // postscaler chain
  // stage inputs as one vector so no stage indexes below bit 0
  assign post_in = {post_tick[4:0], fast_tick};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_post
      oscmc_divider u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .tick_in  (post_in[gi]),
        .tick_out (post_tick[gi]),
        .level    (post_level[gi])
      );
    end
  endgenerate

  always @* begin
    case (internal_freq_select)
      3'h0: next_int_tick = slow_tick;
      3'h1: next_int_tick = post_tick[5];
      3'h2: next_int_tick = post_tick[4];
      3'h3: next_int_tick = post_tick[3];
      3'h4: next_int_tick = post_tick[2];
      3'h5: next_int_tick = post_tick[1];
      3'h6: next_int_tick = post_tick[0];
      3'h7: next_int_tick = fast_tick;
      default: next_int_tick = fast_tick;
    endcase
  end
  assign int_src_tick = next_int_tick;

  always @* begin
    if (int_mode) begin
      next_src_tick = int_src_tick;
    end else if (rc_mode) begin
      next_src_tick = rc_tick;
    end else begin
      next_src_tick = osc_input_pin;
    end
  end

  // crystals wait for start-up; external clock starts at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      ost_count    <= 32'h0;
      startup_done <= 1'b0;
    end else if (mode_loaded && !startup_done) begin
      if (!crystal_mode) begin
        startup_done <= 1'b1;
      end else if (ost_count >= OST_CYCLES - 32'h1) begin
        startup_done <= 1'b1;
      end else begin
        ost_count <= ost_count + 32'h1;
      end
    end
  end

  // system clock tick and quarter-rate output
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_tick   <= 1'b0;
      sys_clk_source <= `OSCMC_SRC_CRYSTAL;
      quarter_count  <= 2'h0;
    end else begin
      sys_clk_tick <= startup_done & next_src_tick;
      sys_clk_source <= int_mode ? `OSCMC_SRC_INTERNAL : rc_mode ? `OSCMC_SRC_RC :
                        ext_mode ? `OSCMC_SRC_EXTERNAL : `OSCMC_SRC_CRYSTAL;
      if (startup_done && next_src_tick) begin
        quarter_count <= quarter_count + 2'h1;
      end
    end
  end

  // pin function assignment
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_output_pin_out  <= 1'b0;
      osc_output_pin_oe_n <= 1'b1;
      osc_input_pin_out   <= 1'b0;
      osc_input_pin_oe_n  <= 1'b1;
      port_a_bit6_io      <= 1'b0;
      port_a_bit7_io      <= 1'b0;
    end else begin
      osc_output_pin_out  <= ~osc_input_pin;
      // mode_reg holds its reset code 3'h0 until captured; no drive before then
      osc_output_pin_oe_n <= ~(crystal_mode & mode_loaded);
      osc_input_pin_out   <= 1'b0;
      osc_input_pin_oe_n  <= 1'b1;
      port_a_bit6_io      <= 1'b0;
      port_a_bit7_io      <= 1'b0;
      if ((mode_reg == CODE_RC) || (mode_reg == CODE_INT1)) begin
        osc_output_pin_out  <= quarter_count[1];
        osc_output_pin_oe_n <= 1'b0;
      end
      if ((mode_reg == CODE_RESISTOR_CAPACITOR_IO_MODE) || ext_mode || (mode_reg == CODE_INT2)) begin
        port_a_bit6_io      <= 1'b1;
        osc_output_pin_out  <= port_a_bit6_out;
        osc_output_pin_oe_n <= port_a_bit6_oe_n;
      end
      if (int_mode) begin
        port_a_bit7_io     <= 1'b1;
        osc_input_pin_out  <= port_a_bit7_out;
        osc_input_pin_oe_n <= port_a_bit7_oe_n;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      slow_clock_run <= 1'b0;
      slow_func_tick <= 1'b0;
    end else begin
      slow_clock_run <= (int_mode && internal_freq_select == `OSCMC_FSEL_SLOW) |
                        pwrt_enable | wdt_enable | two_speed_enable | fscm_enable;
      slow_func_tick <= slow_clock_run & slow_tick;
    end
  end

  // trim is forwarded straight to the analog trim; settle counters are internal
  // only, since software gets no completion flag for a retune
  always @(posedge aclk) begin
    if (!aresetn) begin
      trim_value_out    <= `OSCMC_TRIM_RESET;
      slow_settle_count <= 4'h0;
      fast_settle_count <= 32'h0;
    end else begin
      trim_value_out <= trim_value;
      if (trim_value_out != trim_value) begin
        slow_settle_count <= 4'h8;
        fast_settle_count <= FAST_SETTLE;
      end else begin
        if (slow_settle_count != 4'h0 && slow_tick) begin
          slow_settle_count <= slow_settle_count - 4'h1;
        end
        if (fast_settle_count != 32'h0) begin
          fast_settle_count <= fast_settle_count - 32'h1;
        end
      end
    end
  end

  // axi4-lite write: address and data held in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready        <= 1'b0;
      s_axi_wready         <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `OSCMC_RESP_OKAY;
      aw_held              <= 1'b0;
      w_held               <= 1'b0;
      aw_addr              <= 8'h00;
      w_data               <= 32'h0;
      w_strb               <= 4'h0;
      trim_value           <= `OSCMC_TRIM_RESET;
      internal_freq_select <= `OSCMC_FSEL_RESET;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `OSCMC_RESP_OKAY;
        if (aw_addr == `OSCMC_TRIM_ADDR) begin
          // write takes effect, code keeps running
          if (w_strb[0]) begin
            trim_value <= w_data[5:0];
          end
        end else if (aw_addr == `OSCMC_CTRL_ADDR) begin
          if (w_strb[0]) begin
            internal_freq_select <= w_data[`OSCMC_FSEL_MSB:`OSCMC_FSEL_LSB];
          end
        end else if (aw_addr != `OSCMC_STAT_ADDR) begin
          s_axi_bresp <= `OSCMC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `OSCMC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `OSCMC_RESP_OKAY;
        case (s_axi_araddr)
          `OSCMC_TRIM_ADDR: s_axi_rdata <= {26'h0, trim_value};
          `OSCMC_CTRL_ADDR: s_axi_rdata <= {25'h0, internal_freq_select, 4'h0};
          `OSCMC_STAT_ADDR: s_axi_rdata <= {25'h0, slow_clock_run, startup_done, ext_mode,
                                            int_mode, rc_mode, crystal_mode, mode_loaded};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `OSCMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* verif/oscmc_top_sva.sv */
// oscmc_top_sva.sv: port-level checker for the oscillator mode block.
// assumes one aclk domain with a synchronous active-low reset.
`include "oscmc_defines.vh"
module oscmc_top_chk (
  input logic        aclk,
  input logic        aresetn,
  input logic        port_a_bit6_oe_n,
  input logic        port_a_bit7_oe_n,
  input logic        pwrt_enable,
  input logic        wdt_enable,
  input logic        two_speed_enable,
  input logic        fscm_enable,
  input logic        osc_output_pin_oe_n,
  input logic        osc_input_pin_oe_n,
  input logic        osc_input_pin,
  input logic        osc_output_pin_out,
  input logic        slow_tick,
  input logic        slow_func_tick,
  input logic        port_a_bit6_io,
  input logic        port_a_bit7_io,
  input logic        sys_clk_tick,
  input logic [1:0]  sys_clk_source,
  input logic        startup_done,
  input logic        slow_clock_run,
  input logic [5:0]  trim_value_out,
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_addr;
  logic       any_en;
  assign any_en = pwrt_enable | wdt_enable | two_speed_enable | fscm_enable;
  // read address kept so the answer can be judged after arvalid drops
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_trim;
    s_wr_both and (s_axi_awaddr == `OSCMC_TRIM_ADDR && s_axi_wstrb[0]);
  endsequence
  property p_trim_follow;
    s_wr_trim |-> ##3 trim_value_out == $past(s_axi_wdata[5:0], 3);
  endproperty
  a_trim_follow: assert property (p_trim_follow) else $error("trim output wrong");
  property p_b_after;
    s_wr_both |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_trim_hi;
    s_axi_rvalid && rd_addr == `OSCMC_TRIM_ADDR |-> s_axi_rdata[31:6] == '0;
  endproperty
  a_trim_hi: assert property (p_trim_hi) else $error("trim upper bits set");
  property p_unmapped;
    s_axi_rvalid && !(rd_addr inside {`OSCMC_TRIM_ADDR, `OSCMC_CTRL_ADDR, `OSCMC_STAT_ADDR})
      |-> s_axi_rresp == `OSCMC_RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_bit6_port;
    port_a_bit6_io && $past(port_a_bit6_io) |-> osc_output_pin_oe_n == $past(port_a_bit6_oe_n);
  endproperty
  a_bit6_port: assert property (p_bit6_port) else $error("output pin not port");
  property p_bit7_port;
    port_a_bit7_io && $past(port_a_bit7_io) |-> osc_input_pin_oe_n == $past(port_a_bit7_oe_n);
  endproperty
  a_bit7_port: assert property (p_bit7_port) else $error("input pin not port");
  property p_tick_cause;
    sys_clk_tick |-> $past(startup_done);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("clock before start-up");
  property p_ec_start;
    sys_clk_source == `OSCMC_SRC_EXTERNAL && $past(sys_clk_source, 2) == `OSCMC_SRC_EXTERNAL |-> startup_done;
  endproperty
  a_ec_start: assert property (p_ec_start) else $error("external clock delayed");
  property p_slow_run;
    $past(aresetn) && $past(any_en) |-> slow_clock_run;
  endproperty
  a_slow_run: assert property (p_slow_run) else $error("slow clock stopped");
  property p_xtal_drive;
    sys_clk_source == `OSCMC_SRC_CRYSTAL && !osc_output_pin_oe_n |-> osc_output_pin_out == !$past(osc_input_pin);
  endproperty
  a_xtal_drive: assert property (p_xtal_drive) else $error("crystal drive wrong");
  property p_slow_func;
    slow_func_tick == ($past(slow_clock_run) && $past(slow_tick));
  endproperty
  a_slow_func: assert property (p_slow_func) else $error("slow timer tick wrong");
endmodule
bind oscmc_top oscmc_top_chk chk_u (.*);

/* verif/oscmc_osc_model.sv */
// oscmc_osc_model.sv: far-side timing parts as aclk-synchronous ticks.
// assumes a 25 MHz aclk; rates are the nearest whole divisions of it.
module oscmc_osc_model #(
  parameter int FAST_DIV = 3,
  parameter int SLOW_DIV = 800,
  parameter int RC_DIV   = 5
) (
  input  logic aclk,
  output logic fast_tick,
  output logic slow_tick,
  output logic rc_tick,
  output logic osc_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial {fast_tick, slow_tick, rc_tick, osc_input_pin} = 4'h0;
  always @(posedge aclk) begin
    cnt <= cnt + 1;
    fast_tick <= (cnt % FAST_DIV) == 0;
    slow_tick <= (cnt % SLOW_DIV) == 0;
    rc_tick <= (cnt % RC_DIV) == 0;
    osc_input_pin <= cnt[1];
  end
endmodule

/* verif/oscmc_tb_top.sv */
// oscmc_tb_top.sv: self-checking bench for oscmc_top with the oscillator model.
// assumes default mode codes and an AXI4-Lite master built from tasks here.
`include "oscmc_defines.vh"
module oscmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, osc_input_pin, fast_tick, slow_tick, rc_tick, slow_func_tick;
  logic        pwrt_enable, wdt_enable, two_speed_enable, fscm_enable;
  logic        port_a_bit6_out, port_a_bit6_oe_n, port_a_bit7_out, port_a_bit7_oe_n;
  logic        osc_output_pin_out, osc_output_pin_oe_n, osc_input_pin_out, osc_input_pin_oe_n;
  logic        port_a_bit6_io, port_a_bit7_io, sys_clk_tick, startup_done, slow_clock_run;
  logic [2:0]  osc_mode_select;
  logic [1:0]  sys_clk_source, s_axi_bresp, s_axi_rresp;
  logic [5:0]  trim_value_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  // per mode code: source[3:2], output pin is port[1], input pin is port[0]
  localparam logic [3:0] MT [8] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h6, 4'h9, 4'hB, 4'hE};
  // short crystal wait keeps the mode sweep brief
  oscmc_top #(.OST_CYCLES(32'd4)) dut_u (.*);
  oscmc_osc_model osc_u (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    port_a_bit6_out <= ~port_a_bit6_out;
    port_a_bit7_out <= port_a_bit6_out;
  end
  function automatic logic near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] m);
    aresetn          <= 1'b0;
    osc_mode_select  <= m;
    port_a_bit6_oe_n <= m[0];
    port_a_bit7_oe_n <= m[1];
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !dd) s_axi_wvalid <= 1'b0;
      ad = ad | s_axi_awready;
      dd = dd | s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    e = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    e = s_axi_rresp;
  endtask
  task automatic count(input int n, output int s, output int f, output int o, output int r);
    logic p;
    s = 0;
    f = 0;
    o = 0;
    r = 0;
    p = osc_output_pin_out;
    repeat (n) begin
      @(posedge aclk);
      s += sys_clk_tick;
      f += fast_tick;
      r += rc_tick;
      o += osc_output_pin_out && !p;
      p = osc_output_pin_out;
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  e;
    do_reset(3'h6);
    axi_rd(`OSCMC_TRIM_ADDR, d, e);
    chk(d, 32'h0);
    axi_wr(`OSCMC_TRIM_ADDR, 32'hFFFFFFFF, e);
    chk(e, `OSCMC_RESP_OKAY);
    axi_rd(`OSCMC_TRIM_ADDR, d, e);
    chk(d, 32'h3F);
    axi_wr(`OSCMC_TRIM_ADDR, 32'h20, e);
    axi_rd(`OSCMC_TRIM_ADDR, d, e);
    chk(d, 32'h20);
    chk(trim_value_out, `OSCMC_TRIM_MIN);
    axi_rd(8'h10, d, e);
    chk(e, `OSCMC_RESP_SLVERR);
    axi_wr(8'h10, 32'h1, e);
    chk(e, `OSCMC_RESP_SLVERR);
    axi_rd(`OSCMC_STAT_ADDR, d, e);
    chk(d, 32'h69);
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      do_reset(m[2:0]);
      repeat (20) @(posedge aclk);
      chk(sys_clk_source, MT[m][3:2]);
      chk(port_a_bit6_io, MT[m][1]);
      chk(port_a_bit7_io, MT[m][0]);
      chk(osc_output_pin_oe_n, MT[m][1] & m[0]);
      chk(osc_input_pin_oe_n, !MT[m][0] | m[1]);
      if (MT[m][1]) chk(osc_output_pin_out, !port_a_bit6_out);
      if (MT[m][0]) chk(osc_input_pin_out, port_a_bit6_out);
      chk(slow_clock_run, MT[m][3:2] == 2'h2);
      chk(startup_done, 1'b1);
    end
    $display("test modes done");
  endtask
  task automatic t_rc;
    int s, f, o, r;
    for (int m = 3; m < 5; m++) begin
      do_reset(m[2:0]);
      repeat (10) @(posedge aclk);
      count(400, s, f, o, r);
      chk(near(s, r), 1'b1);
      if (m == 3) chk(near(o, r / 4), 1'b1);
    end
    $display("test rc done");
  endtask
  task automatic t_fsel;
    int s, f, o, r;
    logic [31:0] d;
    logic [1:0]  e;
    do_reset(3'h6);
    for (int k = 1; k < 8; k++) begin
      axi_wr(`OSCMC_CTRL_ADDR, k << 4, e);
      axi_rd(`OSCMC_CTRL_ADDR, d, e);
      chk(d[6:4], k[2:0]);
      count(768, s, f, o, r);
      chk(near(s, f >> (7 - k)), 1'b1);
    end
    $display("test freq select done");
  endtask
  task automatic t_slow;
    do_reset(3'h7);
    repeat (3) @(posedge aclk);
    chk(startup_done, 1'b1);
    for (int i = 0; i < 4; i++) begin
      {pwrt_enable, wdt_enable, two_speed_enable, fscm_enable} <= 4'h1 << i;
      repeat (3) @(posedge aclk);
      chk(slow_clock_run, 1'b1);
    end
    {pwrt_enable, wdt_enable, two_speed_enable, fscm_enable} <= 4'h0;
    repeat (3) @(posedge aclk);
    chk(slow_clock_run, 1'b0);
    $display("test slow clock done");
  endtask
  // cut a hang well past the expected run of about 6600 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    {aresetn, osc_mode_select, pwrt_enable, wdt_enable, two_speed_enable, fscm_enable} = '0;
    {port_a_bit6_out, port_a_bit7_out, port_a_bit6_oe_n, port_a_bit7_oe_n} = 4'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    t_regs();
    t_modes();
    t_rc();
    t_fsel();
    t_slow();
    end_of_test();
  end
endmodule
